// file: pkg/adc_seq_pkg.sv
// package: constants and carrier types for the conversion sequencer
package adc_seq_pkg;
   // ****************************************
   // clock select encodings
   // ****************************************
   localparam logic [1:0] CLK_DIV8 = 2'h0;
   localparam logic [1:0] CLK_DIV32 = 2'h1;
   localparam logic [1:0] CLK_DIV64 = 2'h2;
   localparam logic [1:0] CLK_RC = 2'h3;
   localparam logic [6:0] DIV8_CYCLES = 7'h08;
   localparam logic [6:0] DIV32_CYCLES = 7'h20;
   localparam logic [6:0] DIV64_CYCLES = 7'h40;
   // ****************************************
   // sequence counts, in bit periods
   // ****************************************
   localparam logic [3:0] CONV_PERIODS = 4'hc;
   localparam logic [3:0] RECOVER_PERIODS = 4'h2;
   localparam logic [3:0] RESULT_BITS = 4'ha;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [15:0] CHAN_ANALOG_RESET = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FIRST = 4'h2,
      ST_CONVERT = 4'h4,
      ST_RECOVER = 4'h8
   } seq_state_t;

   typedef struct packed {
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
   } result_pair_t;
endpackage

// file: design/adc_conversion_sequencer.sv
// conversion sequencer: bit period, sequence, abort, recovery, pin readback
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // control
   input wire logic converter_power_on,
   input wire logic [1:0] conv_clock_select,
   input wire logic [3:0] channel_select,
   input wire logic start_set,
   input wire logic start_clear,
   input wire logic done_flag_clear,
   input wire logic internal_rc_clock,
   // pin configuration
   input wire logic [15:0] chan_analog,
   input wire logic [15:0] pin_dir_input,
   input wire logic [15:0] pin_level,
   input wire logic [15:0] pin_out_level,
   // analog front end
   input wire logic comparator_high,
   // status and results
   output logic conversion_busy,
   output logic conversion_done_flag,
   output adc_seq_pkg::result_pair_t result_q,
   output logic holding_capacitor,
   output logic sar_trial_high,
   output logic [9:0] sar_trial_q,
   output logic select_driven_level,
   output logic driven_level,
   output logic [15:0] port_read
);
   // ****************************************
   // bit period generator
   // ****************************************
   logic [6:0] div_cnt_q;
   logic rc_prev_q;
   logic tad_tick;
   adc_seq_pkg::seq_state_t state_q;
   logic [3:0] period_cnt_q;
   logic abort;
   logic start_go;

   function automatic logic [6:0] div_len(input logic [1:0] sel);
      case (sel)
         adc_seq_pkg::CLK_DIV8: div_len = adc_seq_pkg::DIV8_CYCLES;
         adc_seq_pkg::CLK_DIV32: div_len = adc_seq_pkg::DIV32_CYCLES;
         default: div_len = adc_seq_pkg::DIV64_CYCLES;
      endcase
   endfunction

   assign start_go = start_set && converter_power_on && state_q == adc_seq_pkg::ST_IDLE;
   assign abort = (start_clear || !converter_power_on)
      && (state_q == adc_seq_pkg::ST_FIRST || state_q == adc_seq_pkg::ST_CONVERT);

   always_ff @(posedge core_clk) begin
      // restarting on abort too makes the abort recovery two whole periods in the divided modes
      if (reset || start_go || abort) begin
         div_cnt_q <= 7'h00;
      end else if (conv_clock_select != adc_seq_pkg::CLK_RC) begin
         div_cnt_q <= (div_cnt_q == div_len(conv_clock_select) - 7'h01) ? 7'h00 : div_cnt_q + 7'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rc_prev_q <= 1'b0;
      end else begin
         rc_prev_q <= internal_rc_clock;
      end
   end

   assign tad_tick = (conv_clock_select == adc_seq_pkg::CLK_RC) ? (internal_rc_clock && !rc_prev_q)
      : (div_cnt_q == div_len(conv_clock_select) - 7'h01);

   // ****************************************
   // sequence
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= adc_seq_pkg::ST_IDLE;
         period_cnt_q <= 4'h0;
      end else begin
         case (state_q)
            adc_seq_pkg::ST_IDLE: begin
               if (start_go) begin
                  state_q <= adc_seq_pkg::ST_FIRST;
               end
            end
            adc_seq_pkg::ST_FIRST: begin
               if (abort) begin
                  state_q <= adc_seq_pkg::ST_RECOVER;
                  period_cnt_q <= 4'h0;
               end else if (tad_tick) begin
                  state_q <= adc_seq_pkg::ST_CONVERT;
                  period_cnt_q <= 4'h1;
               end
            end
            adc_seq_pkg::ST_CONVERT: begin
               if (abort) begin
                  state_q <= adc_seq_pkg::ST_RECOVER;
                  period_cnt_q <= 4'h0;
               end else if (tad_tick) begin
                  if (period_cnt_q == adc_seq_pkg::CONV_PERIODS - 4'h1) begin
                     state_q <= adc_seq_pkg::ST_RECOVER;
                     period_cnt_q <= 4'h0;
                  end else begin
                     period_cnt_q <= period_cnt_q + 4'h1;
                  end
               end
            end
            adc_seq_pkg::ST_RECOVER: begin
               if (tad_tick) begin
                  if (period_cnt_q == adc_seq_pkg::RECOVER_PERIODS - 4'h1) begin
                     state_q <= adc_seq_pkg::ST_IDLE;
                     period_cnt_q <= 4'h0;
                  end else begin
                     period_cnt_q <= period_cnt_q + 4'h1;
                  end
               end
            end
            default: begin
               state_q <= adc_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // successive approximation
   // ****************************************
   logic done_evt;
   logic [3:0] bit_idx;
   assign done_evt = state_q == adc_seq_pkg::ST_CONVERT && tad_tick && !abort
      && period_cnt_q == adc_seq_pkg::CONV_PERIODS - 4'h1;
   // bit periods 1..10 resolve b9..b0; the rest settle
   assign bit_idx = adc_seq_pkg::RESULT_BITS - period_cnt_q;

   always_ff @(posedge core_clk) begin
      if (reset || start_go) begin
         sar_trial_q <= 10'h200;
      end else if (state_q == adc_seq_pkg::ST_CONVERT && tad_tick && period_cnt_q >= 4'h1
                   && period_cnt_q <= adc_seq_pkg::RESULT_BITS) begin
         sar_trial_q[bit_idx] <= !comparator_high;
         if (bit_idx != 4'h0) begin
            sar_trial_q[bit_idx - 4'h1] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sar_trial_high <= 1'b0;
      end else begin
         sar_trial_high <= state_q == adc_seq_pkg::ST_CONVERT;
      end
   end

   // ****************************************
   // results and flags
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         result_q <= '0;
      end else if (done_evt) begin
         result_q <= {6'h00, sar_trial_q};
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         conversion_done_flag <= 1'b0;
      end else if (done_evt) begin
         conversion_done_flag <= 1'b1;
      end else if (done_flag_clear) begin
         conversion_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         conversion_busy <= 1'b0;
      end else begin
         conversion_busy <= (start_go || conversion_busy) && !done_evt && !abort;
      end
   end

   // capacitor tracks only while idle and powered; never discharged
   always_ff @(posedge core_clk) begin
      if (reset) begin
         holding_capacitor <= 1'b0;
      end else begin
         holding_capacitor <= converter_power_on && state_q == adc_seq_pkg::ST_IDLE && !start_go;
      end
   end

   // ****************************************
   // pin configuration
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         port_read <= adc_seq_pkg::CHAN_ANALOG_RESET;
         select_driven_level <= 1'b0;
         driven_level <= 1'b0;
      end else begin
         port_read <= pin_level & ~chan_analog;
         select_driven_level <= !pin_dir_input[channel_select];
         driven_level <= pin_out_level[channel_select];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // bit periods since start, counted apart from the sequence counter
   logic [3:0] conv_ticks_q;
   always_ff @(posedge core_clk) begin
      if (reset || start_go) begin
         conv_ticks_q <= 4'h0;
      end else if (tad_tick && (state_q == adc_seq_pkg::ST_FIRST || state_q == adc_seq_pkg::ST_CONVERT)) begin
         conv_ticks_q <= conv_ticks_q + 4'h1;
      end
   end

   a_done_flag_set: assert property (@(posedge core_clk) disable iff (reset)
      done_evt |=> conversion_done_flag && !conversion_busy)
      else $error("done flag not set on completion");
   a_abort_keeps_result: assert property (@(posedge core_clk) disable iff (reset)
      abort |=> $stable(result_q) && state_q == adc_seq_pkg::ST_RECOVER)
      else $error("abort changed result");
   a_recover_no_track: assert property (@(posedge core_clk) disable iff (reset)
      state_q == adc_seq_pkg::ST_RECOVER |=> !holding_capacitor)
      else $error("capacitor connected in recovery");
   a_recover_to_idle: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == adc_seq_pkg::ST_RECOVER && tad_tick && period_cnt_q == 4'h1)
      |=> state_q == adc_seq_pkg::ST_IDLE)
      else $error("recovery length wrong");
   a_conv_length: assert property (@(posedge core_clk) disable iff (reset)
      done_evt |-> conv_ticks_q == adc_seq_pkg::CONV_PERIODS - 4'h1)
      else $error("conversion too short");
   a_div_restart: assert property (@(posedge core_clk) disable iff (reset)
      start_go |=> div_cnt_q == 7'h00)
      else $error("divider not restarted");
   a_first_segment: assert property (@(posedge core_clk) disable iff (reset)
      start_go |=> state_q == adc_seq_pkg::ST_FIRST)
      else $error("first segment skipped");
   a_port_analog_zero: assert property (@(posedge core_clk) disable iff (reset)
      chan_analog[0] |=> !port_read[0])
      else $error("analog pin read nonzero");
   c_complete: cover property (@(posedge core_clk) disable iff (reset) done_evt);
   c_abort: cover property (@(posedge core_clk) disable iff (reset) abort);
   c_rc_start: cover property (@(posedge core_clk) disable iff (reset)
      start_go && conv_clock_select == adc_seq_pkg::CLK_RC);
endmodule // adc_conversion_sequencer

`default_nettype wire

// file: tb/adc_front_model.sv
// front-end model: comparator answering the trial word against a held level
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
   // trial side
   input wire logic [9:0] sar_trial_q,
   input wire logic sar_trial_high,
   input wire logic select_driven_level,
   input wire logic driven_level,
   // held level, given as the code it should convert to
   input wire logic [9:0] ain_code,
   // answer
   output logic comparator_high
);
   logic [9:0] level;
   assign level = select_driven_level ? {10{driven_level}} : ain_code;
   // outside trials the answer wanders, so an early sample sees junk
   assign comparator_high = sar_trial_high ? (sar_trial_q > level) : ~sar_trial_q[0];
endmodule // adc_front_model
`default_nettype wire

// file: tb/adc_conversion_sequencer_tb.sv
// testbench: conversions in every clock mode, abort, recovery and pin reads
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
   logic core_clk = 0, reset = 1, converter_power_on = 0, start_set = 0, start_clear = 0, done_flag_clear = 0;
   logic [1:0] conv_clock_select = 2'h0;
   logic [3:0] channel_select = 4'h0;
   logic [15:0] chan_analog = 16'hffff, pin_dir_input = 16'hffff, pin_level = 16'h0000, pin_out_level = 16'h0000;
   logic [5:0] rc_div = 6'h00;
   logic [9:0] ain_code = 10'h000, last;
   logic comparator_high, conversion_busy, conversion_done_flag, holding_capacitor, sar_trial_high;
   logic select_driven_level, driven_level;
   logic [9:0] sar_trial_q;
   logic [15:0] port_read;
   adc_seq_pkg::result_pair_t result_q;
   int mismatches = 0, checks = 0;
   int span_tab[4] = '{8, 32, 64, 64};
   always #20 core_clk = ~core_clk;
   // rc source: one rising edge every 64 core cycles, 2.56 us, above the 1.6 us floor
   // rc runs awake here only to cover select code 11; advisory, no sleep in this block
   always @(posedge core_clk) rc_div <= rc_div + 6'h01;
   wire logic internal_rc_clock = rc_div[5];
   adc_conversion_sequencer uut (.core_clk(core_clk), .reset(reset), .converter_power_on(converter_power_on),
      .conv_clock_select(conv_clock_select), .channel_select(channel_select), .start_set(start_set),
      .start_clear(start_clear), .done_flag_clear(done_flag_clear), .internal_rc_clock(internal_rc_clock),
      .chan_analog(chan_analog), .pin_dir_input(pin_dir_input), .pin_level(pin_level),
      .pin_out_level(pin_out_level), .comparator_high(comparator_high), .conversion_busy(conversion_busy),
      .conversion_done_flag(conversion_done_flag), .result_q(result_q), .holding_capacitor(holding_capacitor),
      .sar_trial_high(sar_trial_high), .sar_trial_q(sar_trial_q), .select_driven_level(select_driven_level),
      .driven_level(driven_level), .port_read(port_read));
   adc_front_model front (.sar_trial_q(sar_trial_q), .sar_trial_high(sar_trial_high),
      .select_driven_level(select_driven_level), .driven_level(driven_level), .ain_code(ain_code),
      .comparator_high(comparator_high));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one full conversion, then recovery and a flag clear
   task automatic conv(input logic [1:0] sel, input int span, input logic [9:0] ain, input logic [9:0] exp);
      int n, first, lo;
      n = 0;
      first = -1;
      // rc edges land at any phase, so a whole first period may be missing
      lo = (sel == adc_seq_pkg::CLK_RC) ? 11 * span : 12 * span - 2;
      @(posedge core_clk) begin
         conv_clock_select <= sel;
         ain_code <= ain;
      end
      @(posedge core_clk) start_set <= 1'b1;
      @(posedge core_clk) start_set <= 1'b0;
      #1;
      chk(16'(conversion_busy), 16'h1);
      while (conversion_done_flag !== 1'b1 && n < 3000) begin
         if (sar_trial_high === 1'b1 && first < 0) first = n;
         tick(1);
         n++;
      end
      chk(16'(n >= lo && n <= 12 * span + 4), 16'h1);
      chk(16'(first >= 0 && first <= span + 3), 16'h1);
      chk(result_q, {6'h00, exp});
      chk(16'({conversion_busy, holding_capacitor}), 16'h0);
      tick(2 * span - 3);
      chk(16'(holding_capacitor), 16'h0);
      tick(6);
      chk(16'({conversion_done_flag, holding_capacitor}), 16'h3);
      @(posedge core_clk) done_flag_clear <= 1'b1;
      @(posedge core_clk) done_flag_clear <= 1'b0;
      tick(1);
      chk(16'(conversion_done_flag), 16'h0);
      last = exp;
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      tick(1);
      chk(result_q, 16'h0000);
      chk(16'({conversion_busy, conversion_done_flag}), 16'h0);
      @(posedge core_clk) converter_power_on <= 1'b1;
      $display("test reset done");
      // /8 and /32 sit below the 1.6 us floor at this clock; the ideal model still answers
      for (int i = 0; i < 4; i++) conv(2'(i), span_tab[i], 10'h2a5 + 10'(i), 10'h2a5 + 10'(i));
      $display("test clock modes done");
      conv(adc_seq_pkg::CLK_DIV8, 8, 10'h3ff, 10'h3ff);
      @(posedge core_clk) ain_code <= 10'h011;
      @(posedge core_clk) start_set <= 1'b1;
      @(posedge core_clk) start_set <= 1'b0;
      tick(40);
      @(posedge core_clk) start_clear <= 1'b1;
      // this start falls into recovery and must be dropped
      @(posedge core_clk) begin
         start_clear <= 1'b0;
         start_set <= 1'b1;
      end
      @(posedge core_clk) start_set <= 1'b0;
      tick(3);
      chk(16'({conversion_busy, conversion_done_flag, holding_capacitor}), 16'h0);
      chk(result_q, {6'h00, last});
      tick(10);
      chk(16'(holding_capacitor), 16'h0);
      tick(10);
      chk(16'(holding_capacitor), 16'h1);
      $display("test abort done");
      @(posedge core_clk) begin
         chan_analog <= 16'h0ff0;
         pin_level <= 16'hffff;
      end
      tick(3);
      chk(port_read, 16'hf00f);
      $display("test port read done");
      @(posedge core_clk) begin
         channel_select <= 4'h5;
         pin_dir_input <= 16'hffdf;
         pin_out_level <= 16'h0020;
      end
      // new channel: let the acquisition interval pass before starting
      tick(500);
      conv(adc_seq_pkg::CLK_DIV64, 64, 10'h155, 10'h3ff);
      @(posedge core_clk) begin
         pin_dir_input <= 16'hffff;
         chan_analog <= 16'h0000;
      end
      conv(adc_seq_pkg::CLK_DIV64, 64, 10'h0c3, 10'h0c3);
      $display("test pin modes done");
      stop_test();
   end
   initial begin
      #800000;
      mismatches++;
      stop_test();
   end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire
